// ---- common/lso_pkg.sv ----
// Constants, register map and shared functions of the LED sink output control block.
package lso_pkg;
  localparam int NUM_CH = 24;
  localparam int GRP_CH = 8;
  localparam int NUM_GRP = 3;
  localparam int TRIM_W = 7;
  localparam int BC_W = 8;
  localparam int SCALE_W = 17;
  localparam logic [8:0] TRIM_HIGH_OFFS = 9'h07F;
  localparam logic [SCALE_W-1:0] SCALE_FULL = 17'h17B83;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_BRIGHT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
  localparam logic [7:0] ADDR_TRIM_BASE = 8'h40;
  localparam logic [7:0] ADDR_TRIM_LAST = 8'h9C;
  localparam int CTRL_DTR_BIT = 0;
  localparam int CTRL_AREP_BIT = 1;
  localparam int CTRL_RANGE_LSB = 2;
  localparam int STAT_TEF_BIT = 0;
  localparam int STAT_TSD_BIT = 1;
  localparam int STAT_HOLD_LSB = 2;
  localparam int IRQ_TSD_BIT = 0;
  localparam int IRQ_TEF_CLR_BIT = 1;
  localparam int IRQ_IBLANK_BIT = 2;
  localparam int IRQ_W = 3;
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [23:0] BRIGHT_RST = 24'h000000;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
  localparam logic [TRIM_W-1:0] TRIM_RST = 7'h00;
  localparam logic [11:0] AREP_LAST = 12'hFFF;
  localparam int CLK_NS = 50;
  localparam int PAIR_STEP_NS = 24;
  localparam int PAIR_STEP_CYC = (PAIR_STEP_NS + CLK_NS - 1) / CLK_NS;

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic is_trim(input logic [7:0] a);
    return (a >= ADDR_TRIM_BASE) && (a <= ADDR_TRIM_LAST) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [4:0] trim_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - ADDR_TRIM_BASE;
    return d[6:2];
  endfunction
endpackage

// ---- design/lso_scale_calc.sv ----
// Pipelined current scale computation from trim, range and brightness.
`timescale 1ns/1ns
`default_nettype none
module lso_scale_calc
  import lso_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [TRIM_W-1:0] trim_i,
  input wire logic [BC_W-1:0] bright_i,
  input wire logic high_range_i,
  input wire logic [4:0] idx_i,
  output logic [SCALE_W-1:0] scale_o,
  output logic [4:0] idx_o
);
  // Trim term in thirds of 127: 127 + 2*trim in high range, 2*trim in low range.
  wire logic [8:0] twice_trim = {1'b0, trim_i, 1'b0};
  wire logic [8:0] trim_term = high_range_i ? (TRIM_HIGH_OFFS + twice_trim) : twice_trim;
  wire logic [SCALE_W-1:0] product = SCALE_W'(trim_term * bright_i);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      scale_o <= '0;
      idx_o <= '0;
    end else begin
      scale_o <= product;
      idx_o <= idx_i;
    end
  end
endmodule // lso_scale_calc
`default_nettype wire

// ---- design/lso_pair_stagger.sv ----
// Staggered switching of the four output pairs of one colour group.
`timescale 1ns/1ns
`default_nettype none
module lso_pair_stagger
  import lso_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [GRP_CH-1:0] on_req_i,
  output logic [GRP_CH-1:0] on_o
);
  localparam int DEPTH = 4 * PAIR_STEP_CYC;
  logic [GRP_CH-1:0] line_q [DEPTH];

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        line_q[i] <= '0;
      end
      on_o <= '0;
    end else begin
      line_q[0] <= on_req_i;
      for (int i = 1; i < DEPTH; i++) begin
        line_q[i] <= line_q[i-1];
      end
      // Pair k (outputs k and k+4) follows the request k+1 steps plus one register cycle later, on and off alike.
      for (int k = 0; k < 4; k++) begin
        on_o[k] <= line_q[(k+1)*PAIR_STEP_CYC-1][k];
        on_o[k+4] <= line_q[(k+1)*PAIR_STEP_CYC-1][k+4];
      end
    end
  end
endmodule // lso_pair_stagger
`default_nettype wire

// ---- design/lso_output_ctrl.sv ----
// Top of the LED sink output control: gating, thermal latch, internal blank, scale codes and registers.
`timescale 1ns/1ns
`default_nettype none
module lso_output_ctrl
  import lso_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic thermal_shutdown_i,
  input wire logic blank_input_n_i,
  input wire logic grayscale_latch_strobe_i,
  input wire logic red_pwm_clock_i,
  input wire logic green_pwm_clock_i,
  input wire logic blue_pwm_clock_i,
  input wire logic [NUM_CH-1:0] pwm_on_i,
  output logic [GRP_CH-1:0] red_sink_outputs_o,
  output logic [GRP_CH-1:0] green_sink_outputs_o,
  output logic [GRP_CH-1:0] blue_sink_outputs_o,
  output logic [NUM_CH*SCALE_W-1:0] sink_scale_o,
  output logic thermal_error_flag_o,
  output logic irq_o
);
  // Register state.
  logic [4:0] ctrl_q;
  logic [23:0] bright_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [TRIM_W-1:0] trim_q [NUM_CH];
  logic [SCALE_W-1:0] raw_q [NUM_CH];
  logic wait_q;

  // Input edge detection and thermal state.
  logic [NUM_GRP-1:0] pclk_q;
  logic gsl_q;
  logic tsd_q;
  logic tef_q;
  logic int_blank_q;
  logic [NUM_GRP-1:0] hold_q;
  logic [NUM_GRP-1:0] armed_q;
  logic [11:0] rep_cnt_q [NUM_GRP];
  logic [4:0] scan_q;
  logic [NUM_CH-1:0] on_q;

  // Bus decode.
  wire logic req = avs_read_i | avs_write_i;
  wire logic take = req & ~wait_q;
  wire logic wr_take = take & avs_write_i;
  wire logic rd_take = take & avs_read_i;
  wire logic hit_ctrl = avs_address_i == ADDR_CTRL;
  wire logic hit_status = avs_address_i == ADDR_STATUS;
  wire logic hit_bright = avs_address_i == ADDR_BRIGHT;
  wire logic hit_istat = avs_address_i == ADDR_IRQ_STAT;
  wire logic hit_imask = avs_address_i == ADDR_IRQ_MASK;
  wire logic hit_trim = is_trim(avs_address_i);
  wire logic [4:0] wr_idx = trim_idx(avs_address_i);

  wire logic [31:0] ctrl_merged = be_merge({27'h0, ctrl_q}, avs_writedata_i, avs_byteenable_i);
  wire logic [31:0] bright_merged = be_merge({8'h00, bright_q}, avs_writedata_i, avs_byteenable_i);
  wire logic [31:0] mask_merged = be_merge({29'h0, irq_mask_q}, avs_writedata_i, avs_byteenable_i);
  wire logic [31:0] trim_merged = be_merge({25'h0, trim_q[wr_idx]}, avs_writedata_i, avs_byteenable_i);

  wire logic dtr_en = ctrl_q[CTRL_DTR_BIT];
  wire logic arep_en = ctrl_q[CTRL_AREP_BIT];
  wire logic [NUM_GRP-1:0] range_high = ctrl_q[CTRL_RANGE_LSB +: NUM_GRP];

  // Edges of the synchronous control inputs.
  wire logic [NUM_GRP-1:0] pclk_now = {blue_pwm_clock_i, green_pwm_clock_i, red_pwm_clock_i};
  wire logic [NUM_GRP-1:0] pwm_edge = pclk_now & ~pclk_q;
  wire logic gsl_rise = grayscale_latch_strobe_i & ~gsl_q;
  wire logic thermal_shutdown = thermal_shutdown_i;
  wire logic tsd_rise = thermal_shutdown & ~tsd_q;
  wire logic blank_any = ~blank_input_n_i | int_blank_q;

  // Auto-repeat: the count wraps on the 4096th edge of a group clock.
  logic [NUM_GRP-1:0] rep_hit;
  always_comb begin
    for (int g = 0; g < NUM_GRP; g++) begin
      rep_hit[g] = pwm_edge[g] & (rep_cnt_q[g] == AREP_LAST);
    end
  end
  wire logic int_blank_d = (dtr_en & gsl_rise) | (arep_en & (|rep_hit));

  // Thermal flag: the shutdown event wins over the strobe that would clear it.
  wire logic tef_d = thermal_shutdown | (tef_q & ~(gsl_rise & ~thermal_shutdown));

  // Per-group recovery: armed by a blank after the heat is gone, released by the group's own clock edge.
  wire logic [NUM_GRP-1:0] release_g = hold_q & armed_q & pwm_edge & {NUM_GRP{~blank_any & ~tef_q & ~thermal_shutdown}};
  wire logic [NUM_GRP-1:0] hold_d = {NUM_GRP{thermal_shutdown}} | (hold_q & ~release_g);
  wire logic [NUM_GRP-1:0] armed_d = hold_q & ~release_g & {NUM_GRP{~thermal_shutdown}} & (armed_q | {NUM_GRP{blank_any}});

  // Gated on requests: blank, internal blank, thermal latch and PWM off-state all switch a channel off.
  logic [NUM_CH-1:0] on_req;
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      on_req[c] = pwm_on_i[c] & ~blank_any & ~hold_q[c/GRP_CH] & ~thermal_shutdown & ~tef_q;
    end
  end

  wire logic [NUM_CH-1:0] stag_on;
  for (genvar g = 0; g < NUM_GRP; g++) begin : g_grp
    lso_pair_stagger u_stagger (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .on_req_i(on_req[g*GRP_CH +: GRP_CH]),
      .on_o(stag_on[g*GRP_CH +: GRP_CH])
    );
  end

  // Scale scan: one channel per cycle through a shared pipelined multiplier.
  wire logic [1:0] scan_grp = scan_q[4:3];
  wire logic [SCALE_W-1:0] calc_scale;
  wire logic [4:0] calc_idx;
  lso_scale_calc u_calc (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .trim_i(trim_q[scan_q]),
    .bright_i(bright_q[8*scan_grp +: 8]),
    .high_range_i(range_high[scan_grp]),
    .idx_i(scan_q),
    .scale_o(calc_scale),
    .idx_o(calc_idx)
  );
  wire logic [4:0] scan_d = (scan_q == 5'(NUM_CH - 1)) ? 5'h00 : scan_q + 5'h01;

  // Interrupt status: events set, a read clears only the bits it returned, so no event is lost; set wins.
  wire logic [IRQ_W-1:0] irq_ev = {int_blank_d, tef_q & ~tef_d, tsd_rise};
  wire logic [IRQ_W-1:0] irq_clr = {IRQ_W{rd_take & hit_istat}} & avs_readdata_o[IRQ_W-1:0];
  wire logic [IRQ_W-1:0] irq_stat_d = (irq_stat_q & ~irq_clr) | irq_ev;

  // Read data selection.
  wire logic [31:0] rd_mux =
    hit_ctrl ? {27'h0, ctrl_q} :
    hit_status ? {27'h0, hold_q, thermal_shutdown, tef_q} :
    hit_bright ? {8'h00, bright_q} :
    hit_istat ? {29'h0, irq_stat_q} :
    hit_imask ? {29'h0, irq_mask_q} :
    hit_trim ? {25'h0, trim_q[wr_idx]} : 32'h0;

  // Bus handshake: one wait cycle, then the access is taken.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wait_q <= 1'b1;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0;
    end else begin
      wait_q <= ~(req & wait_q);
      avs_waitrequest_o <= ~(req & wait_q);
      if (req & wait_q) begin
        avs_readdata_o <= rd_mux;
      end
    end
  end

  // Software registers.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_q <= CTRL_RST;
      bright_q <= BRIGHT_RST;
      irq_mask_q <= IRQ_MASK_RST;
    end else if (wr_take) begin
      if (hit_ctrl) begin
        ctrl_q <= ctrl_merged[4:0];
      end
      if (hit_bright) begin
        bright_q <= bright_merged[23:0];
      end
      if (hit_imask) begin
        irq_mask_q <= mask_merged[IRQ_W-1:0];
      end
    end
  end

  // Trim store, one 7-bit code per channel.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
        trim_q[c] <= TRIM_RST;
      end
    end else if (wr_take & hit_trim) begin
      trim_q[wr_idx] <= trim_merged[TRIM_W-1:0];
    end
  end

  // Raw scale store fed by the scan.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
        raw_q[c] <= '0;
      end
      scan_q <= 5'h00;
    end else begin
      raw_q[calc_idx] <= calc_scale;
      scan_q <= scan_d;
    end
  end

  // Thermal, blank and edge state.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pclk_q <= '0;
      gsl_q <= 1'b0;
      tsd_q <= 1'b0;
      tef_q <= 1'b0;
      int_blank_q <= 1'b0;
      hold_q <= '0;
      armed_q <= '0;
      irq_stat_q <= '0;
    end else begin
      pclk_q <= pclk_now;
      gsl_q <= grayscale_latch_strobe_i;
      tsd_q <= thermal_shutdown;
      tef_q <= tef_d;
      int_blank_q <= int_blank_d;
      hold_q <= hold_d;
      armed_q <= armed_d;
      irq_stat_q <= irq_stat_d;
    end
  end

  // Auto-repeat edge counters, one per group clock, restarted by any blank.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int g = 0; g < NUM_GRP; g++) begin
        rep_cnt_q[g] <= 12'h000;
      end
    end else begin
      for (int g = 0; g < NUM_GRP; g++) begin
        if (blank_any) begin
          rep_cnt_q[g] <= 12'h000;
        end else if (pwm_edge[g]) begin
          rep_cnt_q[g] <= rep_cnt_q[g] + 12'h001;
        end
      end
    end
  end

  // Outputs: on states and gated scale codes register together.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      on_q <= '0;
      sink_scale_o <= '0;
      thermal_error_flag_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      on_q <= stag_on;
      for (int c = 0; c < NUM_CH; c++) begin
        sink_scale_o[c*SCALE_W +: SCALE_W] <= stag_on[c] ? raw_q[c] : '0;
      end
      thermal_error_flag_o <= tef_d;
      irq_o <= |(irq_stat_d & irq_mask_q);
    end
  end

  always_comb begin
    red_sink_outputs_o = on_q[0 +: GRP_CH];
    green_sink_outputs_o = on_q[GRP_CH +: GRP_CH];
    blue_sink_outputs_o = on_q[2*GRP_CH +: GRP_CH];
  end
endmodule // lso_output_ctrl
`default_nettype wire

// ---- tb/lso_ctrl_model.sv ----
// Display controller model driving blank, latch strobe and the group PWM clocks.
`timescale 1ns/1ns
`default_nettype none
module lso_ctrl_model (
  input wire logic clk_i,
  output logic blank_n_o,
  output logic strobe_o,
  output logic [2:0] pwm_o
);
  initial begin
    blank_n_o = 1'b0;
    strobe_o = 1'b0;
    pwm_o = 3'h0;
  end
  task automatic set_blank(input logic v);
    @(posedge clk_i);
    blank_n_o <= v;
  endtask
  task automatic pulse(input logic [2:0] m, input int n);
    repeat (n) begin
      @(posedge clk_i);
      pwm_o <= m;
      @(posedge clk_i);
      pwm_o <= 3'h0;
    end
  endtask
  task automatic strobe();
    @(posedge clk_i);
    strobe_o <= 1'b1;
    @(posedge clk_i);
    strobe_o <= 1'b0;
  endtask
endmodule // lso_ctrl_model
`default_nettype wire

// ---- tb/lso_output_ctrl_monitor.sv ----
// Checker of the LED sink output control ports.
`timescale 1ns/1ns
`default_nettype none
module lso_output_ctrl_monitor
  import lso_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic thermal_shutdown_i,
  input wire logic blank_input_n_i,
  input wire logic grayscale_latch_strobe_i,
  input wire logic [NUM_CH-1:0] pwm_on_i,
  input wire logic [GRP_CH-1:0] red_sink_outputs_o,
  input wire logic [GRP_CH-1:0] green_sink_outputs_o,
  input wire logic [GRP_CH-1:0] blue_sink_outputs_o,
  input wire logic [NUM_CH*SCALE_W-1:0] sink_scale_o,
  input wire logic thermal_error_flag_o
);
  wire [NUM_CH-1:0] on_w = {blue_sink_outputs_o, green_sink_outputs_o, red_sink_outputs_o};
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  property p_blank_off;
    !blank_input_n_i [*7] |-> on_w == 24'h000000;
  endproperty
  a_blank_off: assert property (p_blank_off) else $error("Output on during blank.");
  property p_hot_flag;
    thermal_shutdown_i |=> thermal_error_flag_o;
  endproperty
  a_hot_flag: assert property (p_hot_flag) else $error("Flag not set by over-temperature.");
  property p_hot_off;
    thermal_shutdown_i [*7] |-> on_w == 24'h000000;
  endproperty
  a_hot_off: assert property (p_hot_off) else $error("Output on while hot.");
  property p_flag_off;
    thermal_error_flag_o [*6] |-> on_w == 24'h000000;
  endproperty
  a_flag_off: assert property (p_flag_off) else $error("Output on while flag set.");
  property p_flag_clr;
    $fell(thermal_error_flag_o) |-> !$past(thermal_shutdown_i)
      && ($past(grayscale_latch_strobe_i) || $past(grayscale_latch_strobe_i, 2));
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("Flag cleared without cool strobe.");
  property p_pair_mate;
    $rose(red_sink_outputs_o[4]) && $past(pwm_on_i[0], 2) |-> red_sink_outputs_o[0];
  endproperty
  a_pair_mate: assert property (p_pair_mate) else $error("Pair members split.");
  property p_pair_step;
    $rose(red_sink_outputs_o[1]) && $past(pwm_on_i[0], 3) |-> $past(red_sink_outputs_o[0]);
  endproperty
  a_pair_step: assert property (p_pair_step) else $error("Pair order broken.");
  property p_bus_ans;
    $rose(avs_read_i) || $rose(avs_write_i) |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
  endproperty
  a_bus_ans: assert property (p_bus_ans) else $error("Bus answer timing wrong.");
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    property p_off_scale;
      !on_w[c] |-> sink_scale_o[SCALE_W*c +: SCALE_W] == '0;
    endproperty
    a_off_scale: assert property (p_off_scale) else $error("Scale nonzero on off channel.");
  end
  c_flag_set: cover property ($rose(thermal_error_flag_o));
  c_flag_clr: cover property ($fell(thermal_error_flag_o));
  c_red_on: cover property ($rose(red_sink_outputs_o[0]));
endmodule // lso_output_ctrl_monitor
bind lso_output_ctrl lso_output_ctrl_monitor i_mon (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .thermal_shutdown_i(thermal_shutdown_i), .blank_input_n_i(blank_input_n_i),
  .grayscale_latch_strobe_i(grayscale_latch_strobe_i), .pwm_on_i(pwm_on_i),
  .red_sink_outputs_o(red_sink_outputs_o), .green_sink_outputs_o(green_sink_outputs_o),
  .blue_sink_outputs_o(blue_sink_outputs_o), .sink_scale_o(sink_scale_o),
  .thermal_error_flag_o(thermal_error_flag_o));
`default_nettype wire

// ---- tb/lso_output_ctrl_tb.sv ----
// Self-checking bench of the LED sink output control.
`timescale 1ns/1ns
`default_nettype none
module lso_output_ctrl_tb
  import lso_pkg::*;
;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h00000000;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic thermal_shutdown_i = 1'b0;
  logic [NUM_CH-1:0] pwm_on_i = '0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o, blank_n, strobe, flag, irq;
  logic [2:0] pwm;
  logic [7:0] red_o, green_o, blue_o;
  logic [NUM_CH*SCALE_W-1:0] scale;
  logic [31:0] rd;
  int errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  always #25 clk_i = ~clk_i;
  lso_ctrl_model i_lso_ctrl_model (.clk_i(clk_i), .blank_n_o(blank_n), .strobe_o(strobe), .pwm_o(pwm));
  lso_output_ctrl i_lso_output_ctrl (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .thermal_shutdown_i(thermal_shutdown_i), .blank_input_n_i(blank_n), .grayscale_latch_strobe_i(strobe),
    .red_pwm_clock_i(pwm[0]), .green_pwm_clock_i(pwm[1]), .blue_pwm_clock_i(pwm[2]), .pwm_on_i(pwm_on_i),
    .red_sink_outputs_o(red_o), .green_sink_outputs_o(green_o), .blue_sink_outputs_o(blue_o),
    .sink_scale_o(scale), .thermal_error_flag_o(flag), .irq_o(irq));
  function automatic logic [6:0] tv(input int c);
    return (c == 0) ? 7'h7F : 7'(c * 5);
  endfunction
  function automatic logic [31:0] exp_sc(input int c);
    int b;
    int t;
    b = (c < 8) ? 255 : ((c < 16) ? 128 : 0);
    t = (c < 8 || c >= 16) ? 127 + 2 * tv(c) : 2 * tv(c);
    return 32'(t * b);
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    avs_writedata_i <= d;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    check(rd, exp);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      stop_test();
    end
  end
  initial begin
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rdchk(ADDR_CTRL, 32'h00000000);
    rdchk(ADDR_BRIGHT, 32'h00000000);
    rdchk(ADDR_TRIM_BASE + 8'h04, 32'h00000000);
    rdchk(8'h20, 32'h00000000);
    for (int c = 0; c < NUM_CH; c++) bus(1'b1, ADDR_TRIM_BASE + 8'(4 * c), 32'(tv(c)));
    bus(1'b1, ADDR_BRIGHT, 32'h000000FF);
    avs_byteenable_i <= 4'h2;
    bus(1'b1, ADDR_BRIGHT, 32'h5A5A805A);
    avs_byteenable_i <= 4'hF;
    rdchk(ADDR_BRIGHT, 32'h000080FF);
    bus(1'b1, ADDR_CTRL, 32'h00000014);
    rdchk(ADDR_TRIM_BASE + 8'h08, 32'(tv(2)));
    $display("registers test done");
    pwm_on_i <= '1;
    i_lso_ctrl_model.set_blank(1'b1);
    i_lso_ctrl_model.pulse(3'h7, 1);
    repeat (40) @(posedge clk_i);
    check(32'({blue_o, green_o, red_o}), 32'h00FFFFFF);
    for (int c = 0; c < NUM_CH; c++) check(32'(scale[SCALE_W*c +: SCALE_W]), exp_sc(c));
    check(32'(scale[SCALE_W-1:0]), 32'(SCALE_FULL));
    pwm_on_i <= 24'hFFFDFF;
    repeat (10) @(posedge clk_i);
    check(32'({blue_o, green_o, red_o}), 32'h00FFFDFF);
    check(32'(scale[SCALE_W*9 +: SCALE_W]), 32'h00000000);
    pwm_on_i <= '1;
    i_lso_ctrl_model.set_blank(1'b0);
    repeat (8) @(posedge clk_i);
    check(32'({blue_o, green_o, red_o}), 32'h00000000);
    check(32'(scale[SCALE_W*5 +: SCALE_W]), 32'h00000000);
    i_lso_ctrl_model.set_blank(1'b1);
    i_lso_ctrl_model.pulse(3'h7, 1);
    $display("scale and blank test done");
    bus(1'b1, ADDR_IRQ_MASK, 32'h00000000);
    bus(1'b1, ADDR_CTRL, 32'h00000017);
    repeat (10) @(posedge clk_i);
    bus(1'b0, ADDR_IRQ_STAT, 32'h00000000);
    i_lso_ctrl_model.strobe();
    n = 0;
    while (red_o === 8'hFF && n < 10) begin
      @(posedge clk_i);
      n++;
    end
    check(32'(n < 10), 32'h00000001);
    check(32'(irq), 32'h00000000);
    rdchk(ADDR_IRQ_STAT, 32'h00000004);
    bus(1'b1, ADDR_IRQ_MASK, 32'h00000004);
    i_lso_ctrl_model.pulse(3'h1, 4095);
    rdchk(ADDR_IRQ_STAT, 32'h00000000);
    i_lso_ctrl_model.pulse(3'h1, 1);
    repeat (3) @(posedge clk_i);
    check(32'(irq), 32'h00000001);
    rdchk(ADDR_IRQ_STAT, 32'h00000004);
    repeat (2) @(posedge clk_i);
    check(32'(irq), 32'h00000000);
    $display("internal blank test done");
    bus(1'b1, ADDR_CTRL, 32'h00000014);
    i_lso_ctrl_model.pulse(3'h7, 1);
    thermal_shutdown_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    check(32'(flag), 32'h00000001);
    check(32'({blue_o, green_o, red_o}), 32'h00000000);
    bus(1'b0, ADDR_STATUS, 32'h00000000);
    check(32'(rd[4:0]), 32'h0000001F);
    thermal_shutdown_i <= 1'b0;
    i_lso_ctrl_model.set_blank(1'b0);
    i_lso_ctrl_model.set_blank(1'b1);
    i_lso_ctrl_model.pulse(3'h7, 1);
    repeat (8) @(posedge clk_i);
    check(32'(flag), 32'h00000001);
    check(32'({blue_o, green_o, red_o}), 32'h00000000);
    i_lso_ctrl_model.strobe();
    repeat (4) @(posedge clk_i);
    check(32'(flag), 32'h00000000);
    rdchk(ADDR_IRQ_STAT, 32'h00000003);
    i_lso_ctrl_model.set_blank(1'b0);
    repeat (3) @(posedge clk_i);
    i_lso_ctrl_model.set_blank(1'b1);
    repeat (10) @(posedge clk_i);
    check(32'({blue_o, green_o, red_o}), 32'h00000000);
    i_lso_ctrl_model.pulse(3'h2, 1);
    repeat (8) @(posedge clk_i);
    check(32'({green_o, red_o}), 32'h0000FF00);
    i_lso_ctrl_model.pulse(3'h1, 1);
    repeat (8) @(posedge clk_i);
    check(32'(red_o), 32'h000000FF);
    $display("thermal test done");
    stop_test();
  end
endmodule // lso_output_ctrl_tb
`default_nettype wire
